// ### rtl/psram_pkg.sv
// shared constants for the pipelined burst sram bus model
package psram_pkg;
  // ************************************************************
  // geometry
  // ************************************************************
  localparam int ADDR_W  = 8;
  localparam int LANES   = 4;
  localparam int LANE_W  = 9;
  localparam int DATA_W  = LANES * LANE_W;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int POWER_UP_MS    = 1;
  localparam int POWER_UP_CYC   = (POWER_UP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ************************************************************
  // burst counter
  // ************************************************************
  localparam int BURST_W = 2;
  localparam logic [1:0] BURST_RST = 2'h0;
endpackage : psram_pkg

// ### rtl/psram_sync2.sv
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module psram_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  logic meta_nxt;
  logic q_r;
  logic q_nxt;

  // next values
  always_comb begin
    meta_nxt = rst_i ? RST_VAL : d_i;
    q_nxt    = rst_i ? RST_VAL : meta_r;
  end

  // registers
  always_ff @(posedge clk_i) begin
    meta_r <= meta_nxt;
    q_r    <= q_nxt;
  end

  assign q_o = q_r;
endmodule // psram_sync2

// ### rtl/psram_core.sv
// pipelined synchronous burst sram bus interface, device side
//
// Overview of operation
// RQ1: host waits 1 ms of power before any access; device ignores earlier ones.
// RQ2: selected only when primary_n low, high high and low_n low.
// RQ3: global write low, or gate low with all lane writes low, writes all lanes; code writes no lane on a processor strobe access.
// RQ4: after a write data lines stay undriven until a strobe starts a read.
// RQ5: host deselects the device before or while raising sleep request.
// RQ6: on leaving sleep, data lines stay undriven until a new read.
// RQ7: output enable acts without the clock; high floats, low shows pending data.
// RQ8: sync inputs sampled on rising edge; read data launched from rising edge.
`timescale 1ns/1ps
module psram_core #(
  parameter int POWER_UP_CYC = psram_pkg::POWER_UP_CYC,
  parameter int ADDR_W       = psram_pkg::ADDR_W,
  parameter int LANES        = psram_pkg::LANES,
  parameter int LANE_W       = psram_pkg::LANE_W
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic [ADDR_W-1:0]         addr_i,
  input  wire logic                      chip_enable_primary_n_i,
  input  wire logic                      chip_enable_high_i,
  input  wire logic                      chip_enable_low_n_i,
  input  wire logic                      processor_address_strobe_n_i,
  input  wire logic                      controller_address_strobe_n_i,
  input  wire logic                      advance_n_i,
  input  wire logic                      global_write_n_i,
  input  wire logic                      byte_write_gate_n_i,
  input  wire logic [LANES-1:0]          byte_lane_write_n_i,
  input  wire logic                      output_enable_n_i,
  input  wire logic                      sleep_request_i,
  input  wire logic [LANES*LANE_W-1:0]   data_lines_i,
  output logic      [LANES*LANE_W-1:0]   data_lines_o,
  output logic                           data_lines_oe_o,
  output logic                           ready_o
);
  localparam int DW = LANES * LANE_W;
  localparam int PW = $clog2(POWER_UP_CYC + 1);

  // ************************************************************
  // storage and state
  // ************************************************************
  logic [DW-1:0]     mem_r [2**ADDR_W];
  logic [PW-1:0]     pwr_cnt_r;
  logic [PW-1:0]     pwr_cnt_nxt;
  logic              ready_r;
  logic              ready_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic              active_r;
  logic              active_nxt;
  logic [DW-1:0]     q_r;
  logic [DW-1:0]     q_nxt;
  logic              q_drive_r;
  logic              q_drive_nxt;
  logic              sleep_s;

  // sleep pin is asynchronous: synchronise it
  psram_sync2 #(.RST_VAL(1'b0)) u_sleep_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sleep_request_i),
    .q_o   (sleep_s)
  );

  // ************************************************************
  // decode
  // ************************************************************
  logic selected;
  logic strobe;
  logic new_access;
  logic is_write;
  logic [LANES-1:0] lane_we;
  logic [ADDR_W-1:0] cur_addr;

  always_comb begin
    selected = !chip_enable_primary_n_i && chip_enable_high_i
               && !chip_enable_low_n_i;                              // RQ2
    strobe   = !processor_address_strobe_n_i || !controller_address_strobe_n_i;
    // processor strobe while primary enable is high deselects, never starts an access
    new_access = ready_r && !sleep_s && selected                     // RQ1
                 && (!controller_address_strobe_n_i
                     || (!processor_address_strobe_n_i && !chip_enable_primary_n_i));
    // processor strobe cycles are always reads
    if (!global_write_n_i)
      lane_we = '1;                                                  // RQ3
    else if (!byte_write_gate_n_i)
      lane_we = ~byte_lane_write_n_i;                                // RQ3
    else
      lane_we = '0;
    if (!processor_address_strobe_n_i && new_access)
      lane_we = '0;
    is_write = |lane_we;
    cur_addr = new_access ? addr_i
             : (addr_r + ADDR_W'(!advance_n_i));
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    pwr_cnt_nxt = pwr_cnt_r;
    ready_nxt   = ready_r;
    addr_nxt    = addr_r;
    active_nxt  = active_r;
    q_nxt       = q_r;
    q_drive_nxt = q_drive_r;
    if (rst_i) begin
      pwr_cnt_nxt = '0;
      ready_nxt   = 1'b0;
      addr_nxt    = '0;
      active_nxt  = 1'b0;
      q_nxt       = '0;
      q_drive_nxt = 1'b0;
    end else if (!ready_r) begin
      // power-up wait before first access
      if (pwr_cnt_r == PW'(POWER_UP_CYC - 1))
        ready_nxt = 1'b1;                                            // RQ1
      pwr_cnt_nxt = pwr_cnt_r + PW'(1);
    end else if (sleep_s) begin
      active_nxt  = 1'b0;                                            // RQ5
      q_drive_nxt = 1'b0;                                            // RQ6
    end else if (new_access) begin
      active_nxt  = 1'b1;
      addr_nxt    = addr_i;                                          // RQ8
      q_nxt       = mem_r[addr_i];                                   // RQ8
      q_drive_nxt = !is_write;                                       // RQ4
    end else if (strobe && !selected) begin
      active_nxt  = 1'b0;                                            // RQ2
      q_drive_nxt = 1'b0;
    end else if (active_r && (!advance_n_i || is_write)) begin
      addr_nxt = cur_addr;
      q_nxt    = mem_r[cur_addr];
      if (is_write)
        q_drive_nxt = 1'b0;                                          // RQ4
    end
  end

  // registers
  always_ff @(posedge clk_i) begin
    pwr_cnt_r <= pwr_cnt_nxt;
    ready_r   <= ready_nxt;
    addr_r    <= addr_nxt;
    active_r  <= active_nxt;
    q_r       <= q_nxt;
    q_drive_r <= q_drive_nxt;
  end

  // byte lane writes into the array; a deselect cycle never writes
  always_ff @(posedge clk_i) begin
    if (!rst_i && ready_r && !sleep_s
        && (new_access || (active_r && !strobe))) begin              // RQ2
      for (int i = 0; i < LANES; i++) begin
        if (lane_we[i])
          mem_r[cur_addr][i*LANE_W +: LANE_W] <= data_lines_i[i*LANE_W +: LANE_W];  // RQ3
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign data_lines_o    = q_r;                                      // RQ8
  assign data_lines_oe_o = q_drive_r && !output_enable_n_i;          // RQ7
  assign ready_o         = ready_r;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // power-up and select
  a_no_early_access: assert property (                               // RQ1
    !ready_r |=> !q_drive_r)
    else $error("data driven before power-up wait ended");
  a_ready_hold: assert property (                                    // RQ1
    ready_r |=> ready_r)
    else $error("ready dropped without reset");
  a_deselect_float: assert property (                                // RQ2
    ready_r && !sleep_s && strobe && !selected |=> !q_drive_r)
    else $error("deselected device still drives");

  // writes and the floated bus
  a_write_all_lanes: assert property (                               // RQ3
    new_access && !global_write_n_i && processor_address_strobe_n_i
    |=> mem_r[$past(addr_i)] == $past(data_lines_i))
    else $error("global write missed a lane");
  a_gate_write_lanes: assert property (                              // RQ3
    new_access && global_write_n_i && !byte_write_gate_n_i
    && byte_lane_write_n_i == '0 && processor_address_strobe_n_i
    |=> mem_r[$past(addr_i)] == $past(data_lines_i))
    else $error("gated write missed a lane");
  a_write_float: assert property (                                   // RQ4
    new_access && is_write |=> !q_drive_r)
    else $error("bus driven after write");
  a_float_hold: assert property (                                    // RQ4
    !q_drive_r && !new_access |=> !q_drive_r)
    else $error("bus driven without new read");
  a_sleep_float: assert property (                                   // RQ6
    ready_r && sleep_s |=> !q_drive_r ##0 !active_r)
    else $error("bus driven in or after sleep");

  // read data and output enable
  a_oe_async: assert property (                                      // RQ7
    output_enable_n_i |-> !data_lines_oe_o)
    else $error("output enable high but bus driven");
  a_oe_follow: assert property (                                     // RQ7
    q_drive_r && !output_enable_n_i |-> data_lines_oe_o)
    else $error("output enable low but bus floated");
  a_read_launch: assert property (                                   // RQ8
    new_access && !is_write
    |=> q_drive_r && data_lines_o == mem_r[$past(addr_i)])
    else $error("read data not launched");
  a_burst_step: assert property (                                    // RQ8
    ready_r && !sleep_s && active_r && !strobe && !advance_n_i && !is_write
    |=> data_lines_o == mem_r[$past(addr_r) + ADDR_W'(1)])
    else $error("burst advance did not load next word");

  c_read: cover property (new_access && !is_write ##1 data_lines_oe_o);
  c_write: cover property (new_access && is_write);
  c_sleep: cover property (sleep_s ##1 !sleep_s);
  c_burst: cover property (active_r && !advance_n_i && !new_access);
  c_deselect: cover property (ready_r && strobe && !selected);
endmodule // psram_core

// ### testbench/psram_host.sv
// bus master model driving the sram's inputs
`timescale 1ns/1ps
module psram_host (
  input  wire logic        clk_i,
  output logic [7:0]       addr_o,
  output logic [2:0]       ce_o,
  output logic             proc_as_n_o,
  output logic             ctrl_as_n_o,
  output logic             advance_n_o,
  output logic [5:0]       wr_o,
  output logic             oe_n_o,
  output logic             sleep_o,
  output logic [35:0]      data_o
);
  // ce_o is {primary_n, high, low_n}; wr_o is {global_n, gate_n, lanes_n}
  initial begin
    {addr_o, data_o, sleep_o, oe_n_o} = '0;
    {proc_as_n_o, ctrl_as_n_o, advance_n_o, wr_o} = 9'h1FF;
    ce_o = 3'h4;
  end
  // one strobe cycle, driven just after an edge, held to the next edge
  task automatic access(input logic ctrl, input logic [2:0] ce, input logic [5:0] wr,
                        input logic [7:0] a, input logic [35:0] d);
    @(posedge clk_i);
    #10;
    ce_o = ce;
    addr_o = a;
    data_o = d;
    wr_o = wr;
    if (ctrl) ctrl_as_n_o = 1'b0;
    else proc_as_n_o = 1'b0;
    @(posedge clk_i);
    #10;
    {proc_as_n_o, ctrl_as_n_o, wr_o} = 8'hFF;
    data_o = ~d; // released bus shows a changed pattern
  endtask
  // deselect cycle first, then sleep held for some cycles
  task automatic snooze(input int n);
    access(1'b1, 3'h4, 6'h3F, 8'h00, 36'h0);
    sleep_o = 1'b1;
    repeat (n) @(posedge clk_i);
    #10 sleep_o = 1'b0;
  endtask
  // output enable changed just after an edge, acting between sampling edges
  task automatic drive_oe_n(input logic v);
    @(posedge clk_i);
    #10;
    oe_n_o = v;
  endtask
  // one burst advance cycle with no strobe
  task automatic burst_step;
    @(posedge clk_i);
    #10;
    advance_n_o = 1'b0;
    @(posedge clk_i);
    #10;
    advance_n_o = 1'b1;
  endtask
endmodule // psram_host

// ### testbench/test_pipelined_sram_bus_cycle_rules.sv
// self-checking bench for the sram bus interface
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_pipelined_sram_bus_cycle_rules;
  localparam logic [35:0] D1 = 36'h123456789;
  localparam logic [35:0] D2 = 36'hABCDEF012;
  localparam logic [35:0] D3 = 36'h0F1E2D3C4;
  localparam logic [2:0]  SEL = 3'h2;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr;
  logic [2:0] ce;
  logic [5:0] wr;
  logic [35:0] dq_in, dq_out;
  logic pas_n, cas_n, adv_n, oe_n, slp, oe, rdy;
  int miscompares = 0;
  int comparisons = 0;
  always #50 clk_i = ~clk_i;
  psram_host u_host (.clk_i(clk_i), .addr_o(addr), .ce_o(ce), .proc_as_n_o(pas_n),
    .ctrl_as_n_o(cas_n), .advance_n_o(adv_n), .wr_o(wr), .oe_n_o(oe_n),
    .sleep_o(slp), .data_o(dq_in));
  psram_core #(.POWER_UP_CYC(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr),
    .chip_enable_primary_n_i(ce[2]), .chip_enable_high_i(ce[1]),
    .chip_enable_low_n_i(ce[0]), .processor_address_strobe_n_i(pas_n),
    .controller_address_strobe_n_i(cas_n), .advance_n_i(adv_n),
    .global_write_n_i(wr[5]), .byte_write_gate_n_i(wr[4]),
    .byte_lane_write_n_i(wr[3:0]), .output_enable_n_i(oe_n), .sleep_request_i(slp),
    .data_lines_i(dq_in), .data_lines_o(dq_out), .data_lines_oe_o(oe), .ready_o(rdy));
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // early read is ignored, then ready rises within a bound
  task automatic t_power;
    int i;
    u_host.access(1'b1, SEL, 6'h3F, 8'h10, 36'h0);
    `CHK("early oe", 1'b0, oe)
    `CHK("early ready", 1'b0, rdy)
    for (i = 0; i < 20 && rdy !== 1'b1; i++) begin
      @(posedge clk_i);
      #10;
    end
    if (rdy !== 1'b1) begin miscompares++; test_done(); end
  endtask
  // both full-width write forms, bus floats after write, data read back
  task automatic t_write;
    u_host.access(1'b1, SEL, 6'h1F, 8'h21, D1);
    `CHK("oe after write", 1'b0, oe)
    u_host.access(1'b1, SEL, 6'h20, 8'h42, D2);
    `CHK("oe after gate write", 1'b0, oe)
    u_host.access(1'b0, SEL, 6'h3F, 8'h21, D2);
    `CHK("read global", D1, dq_out)
    `CHK("oe on read", 1'b1, oe)
    u_host.access(1'b1, SEL, 6'h3F, 8'h42, D1);
    `CHK("read gated", D2, dq_out)
  endtask
  // a read followed by one advance shows the next word
  task automatic t_burst;
    u_host.access(1'b1, SEL, 6'h1F, 8'h22, D3);
    u_host.access(1'b1, SEL, 6'h3F, 8'h21, 36'h0);
    u_host.burst_step();
    `CHK("burst next word", D3, dq_out)
    `CHK("burst oe", 1'b1, oe)
  endtask
  // one failing pattern per enable (primary_n, high, low_n) floats the bus
  task automatic t_desel;
    logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
    foreach (bad[k]) begin
      u_host.access(1'b1, SEL, 6'h3F, 8'h21, 36'h0);
      u_host.access(1'b1, bad[k], 6'h3F, 8'h21, 36'h0);
      `CHK("deselect oe", 1'b0, oe)
    end
  endtask
  // output enable acts between clock edges
  task automatic t_oe;
    u_host.access(1'b1, SEL, 6'h3F, 8'h21, 36'h0);
    u_host.drive_oe_n(1'b1);
    #20 `CHK("oe high floats", 1'b0, oe)
    u_host.drive_oe_n(1'b0);
    #20 `CHK("oe low drives", 1'b1, oe)
    `CHK("oe data", D1, dq_out)
  endtask
  // leaving sleep keeps the bus floated until a new read
  task automatic t_sleep;
    u_host.access(1'b1, SEL, 6'h3F, 8'h21, 36'h0);
    u_host.snooze(6);
    repeat (4) @(posedge clk_i);
    #10 `CHK("oe after sleep", 1'b0, oe)
    u_host.access(1'b1, SEL, 6'h3F, 8'h42, 36'h0);
    `CHK("read after sleep", D2, dq_out)
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (3) @(posedge clk_i);
    #10 rst_i = 1'b0;
    t_power();
    t_write();
    t_burst();
    t_desel();
    t_oe();
    t_sleep();
    test_done();
  end
endmodule // test_pipelined_sram_bus_cycle_rules
